// [verilog/lift_ctrl_pkg.sv]
/*
  Package for the lift door and run mode control block: timing constants,
  floor count, door states and service modes.
  Assumes a 100 MHz system clock.
*/
package lift_ctrl_pkg;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          TICK_MS       = 100;           // Timebase step
  localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int          OFFSET_S      = 2;             // Hold offset
  localparam logic [7:0]  OFFSET_TICKS  = 8'(OFFSET_S * 1000 / TICK_MS);
  localparam logic [7:0]  HOLD_MIN      = 8'h01;
  localparam logic [23:0] TICK_ONE      = 24'h00_0001;
  localparam logic [7:0]  CNT_ONE       = 8'h01;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;

  // -------------------------------------------------------------------------
  // Geometry
  // -------------------------------------------------------------------------
  localparam int          FLOORS        = 8;
  localparam int          FW            = 3;             // Floor index width
  localparam logic [2:0]  FLOOR_BOTTOM  = 3'h0;
  localparam logic [2:0]  FLOOR_TOP     = 3'h7;
  localparam logic [7:0]  CALL_NONE     = 8'h00;
  localparam logic [7:0]  OVL_CODE      = 8'h0C;         // Overload display code

  // -------------------------------------------------------------------------
  // States and modes
  // -------------------------------------------------------------------------
  typedef enum logic [4:0] {
    DOOR_CLOSED  = 5'b0_0001,
    DOOR_OPENING = 5'b0_0010,
    DOOR_HOLD    = 5'b0_0100,
    DOOR_CLOSING = 5'b0_1000,
    DOOR_WAIT    = 5'b1_0000
  } door_type;

  typedef enum logic [2:0] {
    MODE_AUTO      = 3'b001,
    MODE_ATTENDANT = 3'b010,
    MODE_INSPECT   = 3'b100
  } mode_type;

endpackage

// [verilog/lift_door_ctrl.sv]
/*
  Lift door and run mode control: selects service mode, sequences the door,
  latches car and landing calls, and handles reopen triggers and overload.
  Assumes all inputs synchronous to clk_sys; door operator reports limits;
  stopped/levelling flags come from the drive side.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1 - Auto and attendant service open the door whenever the car stops; code opens it only when level_zone is also set.
// RQ2 - Automatic service holds the open door, then closes after the delay.
// RQ3 - The close pushbutton starts closing in automatic and attendant service.
// RQ4 - Car calls latch when entered; calls wrong for travel are dropped.
// RQ5 - A landing call stops the car only when its direction matches travel.
// RQ6 - At terminal floors automatic service answers opposite direction calls too.
// RQ7 - Automatic service needs inspection normal, all switches auto, selector auto.
// RQ8 - Attendant service: switches normal, selector attendant; close only by button.
// RQ9 - Inspection runs the car up or down only while its button is held.
// RQ10 - Inspection stops the car as soon as the held button is released.
// RQ11 - Auto/inspection switches resolve by priority: car top, car, cabinet.
// RQ12 - After power-up inside a levelling zone the door opens itself.
// RQ13 - Close delay is hold time minus 2 s for landing only, plus 2 s both.
// RQ14 - Same-floor landing call while closing or idle closed reopens the door.
// RQ15 - Safety edge or curtain during closing reopens, closes once clear.
// RQ16 - Overload keeps door open, lamp, buzzer, code shown, travel inhibited.
// RQ17 - Clearing overload removes its indications and resumes normal service.
// RQ18 - Hold delay counts ticks of a fixed timebase from the system clock.
// RQ19 - Reopen triggers beat both the close button and the auto-close timer.
module lift_door_ctrl (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Mode switches (1 = inspection / attendant)
  input  wire logic       insp_top,
  input  wire logic       insp_car,
  input  wire logic       insp_cabinet,
  input  wire logic       sel_attendant,
  // Inspection pushbuttons
  input  wire logic       insp_up_btn,
  input  wire logic       insp_down_btn,
  // Car state from drive side
  input  wire logic [2:0] cur_floor,
  input  wire logic       car_stopped,
  input  wire logic       level_zone,
  input  wire logic       travel_up,
  // Calls
  input  wire logic [7:0] car_call_btn,
  input  wire logic [7:0] land_up_btn,
  input  wire logic [7:0] land_down_btn,
  // Door and safety
  input  wire logic       close_btn,
  input  wire logic       door_open_lim,
  input  wire logic       door_closed_lim,
  input  wire logic       safety_edge,
  input  wire logic       overload,
  input  wire logic [7:0] hold_time,          // Hold time T in 100 ms ticks
  // Door operator
  output logic            door_open_cmd,
  output logic            door_close_cmd,
  // Travel
  output logic            travel_enable,
  output logic            insp_run_up,
  output logic            insp_run_down,
  output logic            stop_here,
  // Calls and indications
  output logic [7:0]      car_calls,
  output logic [7:0]      land_up_calls,
  output logic [7:0]      land_down_calls,
  output logic            overload_lamp,
  output logic            buzzer,
  output logic [7:0]      overload_indication_code,
  output logic [2:0]      mode
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // One-hot mask of a floor
  function automatic logic [7:0] floor_bit(input logic [2:0] f);
    floor_bit = 8'(lift_ctrl_pkg::CNT_ONE << f);
  endfunction

  // Floors strictly above (dir=1) or below (dir=0) the given floor
  function automatic logic [7:0] beyond(input logic [2:0] f, input logic dir);
    logic [7:0] m;
    m = 8'(floor_bit(f) - lift_ctrl_pkg::CNT_ONE);
    beyond = dir ? ~(m | floor_bit(f)) : m;
  endfunction

  lift_ctrl_pkg::mode_type next_mode;
  lift_ctrl_pkg::door_type door;
  lift_ctrl_pkg::door_type next_door;
  logic [23:0] tick_cnt;
  logic        tick;
  logic [7:0]  hold_cnt;
  logic [7:0]  hold_load;
  logic        hold_done;
  logic        was_stopped;
  logic        power_up;
  logic        same_land;
  logic        reopen;
  logic        auto_svc;
  logic        do_close;

  // -------------------------------------------------------------------------
  // Mode selection
  // -------------------------------------------------------------------------
  // RQ7 RQ8 RQ11 mode priority
  // Car top over car over cabinet; any inspection wins over selector
  always_comb begin
    if (insp_top) begin
      next_mode = lift_ctrl_pkg::MODE_INSPECT;
    end else if (insp_car) begin
      next_mode = lift_ctrl_pkg::MODE_INSPECT;
    end else if (insp_cabinet) begin
      next_mode = lift_ctrl_pkg::MODE_INSPECT;
    end else if (sel_attendant) begin
      next_mode = lift_ctrl_pkg::MODE_ATTENDANT;
    end else begin
      next_mode = lift_ctrl_pkg::MODE_AUTO;
    end
  end

  // Registered mode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode <= lift_ctrl_pkg::MODE_INSPECT;
    end else begin
      mode <= next_mode;
    end
  end

  assign auto_svc = (mode == lift_ctrl_pkg::MODE_AUTO);

  // -------------------------------------------------------------------------
  // Inspection run
  // -------------------------------------------------------------------------
  // RQ9 RQ10 held button run
  // Run only while one button held, stop next edge on release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      insp_run_up   <= 1'b0;
      insp_run_down <= 1'b0;
    end else begin
      insp_run_up   <= (next_mode == lift_ctrl_pkg::MODE_INSPECT) && insp_up_btn
                       && !insp_down_btn && !overload;
      insp_run_down <= (next_mode == lift_ctrl_pkg::MODE_INSPECT) && insp_down_btn
                       && !insp_up_btn && !overload;
    end
  end

  // -------------------------------------------------------------------------
  // Calls
  // -------------------------------------------------------------------------
  // RQ4 car call latch
  // Latch new calls; drop those behind travel and the one answered
  always_ff @(posedge clk_sys) begin
    if (!resetn || mode == lift_ctrl_pkg::MODE_INSPECT) begin
      car_calls <= lift_ctrl_pkg::CALL_NONE;
    end else begin
      car_calls <= (car_calls | car_call_btn)
                   & beyond(cur_floor, travel_up)
                   | (car_call_btn & ~floor_bit(cur_floor));
    end
  end

  // Landing calls latch; cleared at the floor when the door opens
  always_ff @(posedge clk_sys) begin
    if (!resetn || mode == lift_ctrl_pkg::MODE_INSPECT) begin
      land_up_calls   <= lift_ctrl_pkg::CALL_NONE;
      land_down_calls <= lift_ctrl_pkg::CALL_NONE;
    end else if (door == lift_ctrl_pkg::DOOR_OPENING) begin
      land_up_calls   <= (land_up_calls | land_up_btn) & ~floor_bit(cur_floor);
      land_down_calls <= (land_down_calls | land_down_btn) & ~floor_bit(cur_floor);
    end else begin
      land_up_calls   <= land_up_calls | land_up_btn;
      land_down_calls <= land_down_calls | land_down_btn;
    end
  end

  // RQ5 RQ6 stop decision
  // Stop on own car call, same-direction landing call, or terminal reversal
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stop_here <= 1'b0;
    end else begin
      stop_here <= |(car_calls & floor_bit(cur_floor))
                   || (travel_up && |(land_up_calls & floor_bit(cur_floor)))
                   || (!travel_up && |(land_down_calls & floor_bit(cur_floor)))
                   || (auto_svc && cur_floor == lift_ctrl_pkg::FLOOR_TOP
                       && land_down_calls[lift_ctrl_pkg::FLOOR_TOP])
                   || (auto_svc && cur_floor == lift_ctrl_pkg::FLOOR_BOTTOM
                       && land_up_calls[lift_ctrl_pkg::FLOOR_BOTTOM]);
    end
  end

  // -------------------------------------------------------------------------
  // Timebase and hold timer
  // -------------------------------------------------------------------------
  // RQ18 fixed timebase
  always_ff @(posedge clk_sys) begin
    if (!resetn || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + lift_ctrl_pkg::TICK_ONE;
    end
  end
  assign tick = (tick_cnt == 24'(lift_ctrl_pkg::TICK_CYCLES - 1));

  // RQ13 delay from hold time
  always_comb begin
    hold_load = hold_time;
    if (|(land_up_calls | land_down_calls) && |car_calls) begin
      hold_load = 8'(hold_time + lift_ctrl_pkg::OFFSET_TICKS);
    end else if (|(land_up_calls | land_down_calls)) begin
      hold_load = (hold_time > lift_ctrl_pkg::OFFSET_TICKS)
                  ? 8'(hold_time - lift_ctrl_pkg::OFFSET_TICKS) : lift_ctrl_pkg::HOLD_MIN;
    end
  end

  // Reload on entry to hold, count down on ticks
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hold_cnt <= lift_ctrl_pkg::CNT_ZERO;
    end else if (door != lift_ctrl_pkg::DOOR_HOLD || reopen) begin
      hold_cnt <= hold_load;
    end else if (tick && hold_cnt != lift_ctrl_pkg::CNT_ZERO) begin
      hold_cnt <= hold_cnt - lift_ctrl_pkg::CNT_ONE;
    end
  end
  assign hold_done = (hold_cnt == lift_ctrl_pkg::CNT_ZERO);

  // -------------------------------------------------------------------------
  // Door sequence
  // -------------------------------------------------------------------------
  // Stop edge and power-up flag
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      was_stopped <= 1'b1;
      power_up    <= 1'b1;
    end else begin
      was_stopped <= car_stopped;
      power_up    <= 1'b0;
    end
  end

  assign same_land = |((land_up_calls | land_down_calls | land_up_btn | land_down_btn)
                       & floor_bit(cur_floor));
  // RQ19 reopen priority
  assign reopen   = overload || safety_edge || same_land;
  assign do_close = !reopen && (close_btn || (auto_svc && hold_done));

  // RQ1 RQ2 RQ3 RQ8 RQ12 RQ14 RQ15 door transitions
  always_comb begin
    next_door = door;
    case (door)
      lift_ctrl_pkg::DOOR_CLOSED: begin
        if (car_stopped && level_zone && ((power_up && next_mode != lift_ctrl_pkg::MODE_INSPECT)
            || (mode != lift_ctrl_pkg::MODE_INSPECT && (!was_stopped || reopen)))) begin
          next_door = lift_ctrl_pkg::DOOR_OPENING;
        end
      end
      lift_ctrl_pkg::DOOR_OPENING: begin
        if (door_open_lim) begin
          next_door = lift_ctrl_pkg::DOOR_HOLD;
        end
      end
      lift_ctrl_pkg::DOOR_HOLD: begin
        if (do_close) begin
          next_door = lift_ctrl_pkg::DOOR_CLOSING;
        end
      end
      lift_ctrl_pkg::DOOR_CLOSING: begin
        if (safety_edge) begin
          next_door = lift_ctrl_pkg::DOOR_WAIT;
        end else if (reopen) begin
          next_door = lift_ctrl_pkg::DOOR_OPENING;
        end else if (door_closed_lim) begin
          next_door = lift_ctrl_pkg::DOOR_CLOSED;
        end
      end
      lift_ctrl_pkg::DOOR_WAIT: begin
        if (!safety_edge && door_open_lim && !overload) begin
          next_door = lift_ctrl_pkg::DOOR_CLOSING;
        end
      end
      default: next_door = lift_ctrl_pkg::DOOR_CLOSED;
    endcase
  end

  // Door state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      door <= lift_ctrl_pkg::DOOR_CLOSED;
    end else begin
      door <= next_door;
    end
  end

  // Door operator commands from next state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      door_open_cmd  <= 1'b0;
      door_close_cmd <= 1'b0;
    end else begin
      door_open_cmd  <= (next_door == lift_ctrl_pkg::DOOR_OPENING)
                        || (next_door == lift_ctrl_pkg::DOOR_WAIT);
      door_close_cmd <= (next_door == lift_ctrl_pkg::DOOR_CLOSING);
    end
  end

  // -------------------------------------------------------------------------
  // Overload and travel
  // -------------------------------------------------------------------------
  // RQ16 RQ17 overload indications
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      overload_lamp            <= 1'b0;
      buzzer                   <= 1'b0;
      overload_indication_code <= lift_ctrl_pkg::CALL_NONE;
      travel_enable            <= 1'b0;
    end else begin
      overload_lamp            <= overload;
      buzzer                   <= overload;
      overload_indication_code <= overload ? lift_ctrl_pkg::OVL_CODE
                                           : lift_ctrl_pkg::CALL_NONE;
      travel_enable            <= !overload && mode != lift_ctrl_pkg::MODE_INSPECT
                                  && next_door == lift_ctrl_pkg::DOOR_CLOSED
                                  && door_closed_lim;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_overload_no_travel: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ16
    overload |=> !travel_enable && overload_lamp && buzzer)
    else $error("travel or indication wrong under overload");
  a_overload_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ17
    !overload |=> !overload_lamp && overload_indication_code == 8'h00)
    else $error("overload indication stuck");
  a_insp_release_stop: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ10
    !insp_up_btn |=> !insp_run_up)
    else $error("inspection run continued after release");
  a_insp_only_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ9
    (insp_run_up || insp_run_down) |-> $past(insp_top || insp_car || insp_cabinet))
    else $error("inspection run outside inspection");
  a_mode_priority: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ11
    (insp_top || insp_car || insp_cabinet) |=> mode == 3'b100)
    else $error("inspection switch not honoured");
  a_attendant_select: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (!insp_top && !insp_car && !insp_cabinet && sel_attendant) |=> mode == 3'b010)
    else $error("attendant mode not entered");
  a_auto_select: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
    (!insp_top && !insp_car && !insp_cabinet && !sel_attendant) |=> mode == 3'b001)
    else $error("auto mode not entered");
  a_reopen_beats_close: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ19
    (door == lift_ctrl_pkg::DOOR_HOLD && reopen) |=> !door_close_cmd)
    else $error("close issued despite reopen trigger");
  a_edge_reopens: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ15
    (door == lift_ctrl_pkg::DOOR_CLOSING && safety_edge) |=> door_open_cmd)
    else $error("safety edge did not reopen door");
  a_close_button: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
    (door == lift_ctrl_pkg::DOOR_HOLD && close_btn && !reopen) |=> door_close_cmd)
    else $error("close button ignored");

endmodule
`default_nettype wire

// [tb/door_operator_model.sv]
/*
  Behavioural door operator for the lift door control bench.
  Assumes door commands are levels from the design; limits move after a travel time.
*/
`timescale 1ns/1ps
`default_nettype none
module door_operator_model #(
  parameter int TRAVEL = 6
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Commands
  input  wire logic door_open_cmd,
  input  wire logic door_close_cmd,
  // Limits
  output logic      door_open_lim,
  output logic      door_closed_lim
);
  int cnt;

  // ---------------------------------------------------------------------------
  // Door motion
  // ---------------------------------------------------------------------------
  // Leaving a limit clears it at once; the far limit comes after the travel time
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt             <= 0;
      door_open_lim   <= 1'b0;
      door_closed_lim <= 1'b1;
    end else if (door_open_cmd && !door_open_lim) begin
      door_closed_lim <= 1'b0;
      cnt             <= cnt + 1;
      if (cnt >= TRAVEL) begin
        door_open_lim <= 1'b1;
        cnt           <= 0;
      end
    end else if (door_close_cmd && !door_closed_lim) begin
      door_open_lim <= 1'b0;
      cnt           <= cnt + 1;
      if (cnt >= TRAVEL) begin
        door_closed_lim <= 1'b1;
        cnt             <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// [tb/lift_door_ctrl_tb.sv]
/*
  Self-checking bench for the lift door and run mode control.
  Assumes the package timebase is long, so auto-close is run with a zero hold time only.
*/
`timescale 1ns/1ps
`default_nettype none
module lift_door_ctrl_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic insp_top = 1'b0, insp_car = 1'b0, insp_cabinet = 1'b0, sel_attendant = 1'b0;
  logic insp_up_btn = 1'b0, insp_down_btn = 1'b0;
  logic [2:0] cur_floor = 3'h2;
  logic car_stopped = 1'b0, level_zone = 1'b1, travel_up = 1'b1;
  logic [7:0] car_call_btn = 8'h00, land_up_btn = 8'h00, land_down_btn = 8'h00;
  logic close_btn = 1'b0, safety_edge = 1'b0, overload = 1'b0;
  logic [7:0] hold_time = 8'h32;
  logic door_open_lim, door_closed_lim, door_open_cmd, door_close_cmd;
  logic travel_enable, insp_run_up, insp_run_down, stop_here, overload_lamp, buzzer;
  logic [7:0] car_calls, land_up_calls, land_down_calls, overload_indication_code;
  logic [2:0] mode;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;

  // ---------------------------------------------------------------------------
  // Clock, timeout and instances
  // ---------------------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  lift_door_ctrl dut (
    .clk_sys(clk_sys), .resetn(resetn), .insp_top(insp_top), .insp_car(insp_car),
    .insp_cabinet(insp_cabinet), .sel_attendant(sel_attendant), .insp_up_btn(insp_up_btn),
    .insp_down_btn(insp_down_btn), .cur_floor(cur_floor), .car_stopped(car_stopped),
    .level_zone(level_zone), .travel_up(travel_up), .car_call_btn(car_call_btn),
    .land_up_btn(land_up_btn), .land_down_btn(land_down_btn), .close_btn(close_btn),
    .door_open_lim(door_open_lim), .door_closed_lim(door_closed_lim),
    .safety_edge(safety_edge), .overload(overload), .hold_time(hold_time),
    .door_open_cmd(door_open_cmd), .door_close_cmd(door_close_cmd),
    .travel_enable(travel_enable), .insp_run_up(insp_run_up), .insp_run_down(insp_run_down),
    .stop_here(stop_here), .car_calls(car_calls), .land_up_calls(land_up_calls),
    .land_down_calls(land_down_calls), .overload_lamp(overload_lamp), .buzzer(buzzer),
    .overload_indication_code(overload_indication_code), .mode(mode));

  door_operator_model door_op (
    .clk_sys(clk_sys), .resetn(resetn), .door_open_cmd(door_open_cmd),
    .door_close_cmd(door_close_cmd), .door_open_lim(door_open_lim),
    .door_closed_lim(door_closed_lim));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: %s got %h", $time, msg, got);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return door_open_cmd;
      1: return door_close_cmd;
      2: return travel_enable;
      3: return stop_here;
      default: return overload_lamp;
    endcase
  endfunction

  // Wait a bounded time for an output to reach a level
  task automatic wait_for(input int sel, input logic val, input string msg);
    int n;
    n = 0;
    while (pick(sel) !== val && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check_bit(pick(sel), val, msg);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    step(8);
    resetn = 1'b1;
    step(3);
    check_vec({5'h00, mode}, 8'h01, "auto mode");
    car_stopped = 1'b1;
    wait_for(0, 1'b1, "open at stop");
    while (door_open_lim !== 1'b1 && cycles < 19000) step(1);
    close_btn = 1'b1;
    wait_for(1, 1'b1, "close on button");
    close_btn = 1'b0;
    step(2);
    safety_edge = 1'b1;
    wait_for(0, 1'b1, "reopen on edge");
    check_bit(door_close_cmd, 1'b0, "close dropped on edge");
    step(15);
    safety_edge = 1'b0;
    wait_for(1, 1'b1, "reclose when clear");
    wait_for(2, 1'b1, "travel once closed");
    // same-floor landing call while idle closed
    land_up_btn = 8'h04;
    step(1);
    land_up_btn = 8'h00;
    wait_for(0, 1'b1, "reopen on landing call");
    while (door_open_lim !== 1'b1 && cycles < 19000) step(1);
    // overload holds the door and inhibits travel
    overload = 1'b1;
    close_btn = 1'b1;
    wait_for(4, 1'b1, "overload lamp");
    step(10);
    check_bit(buzzer, 1'b1, "buzzer on");
    check_vec(overload_indication_code, 8'h0C, "overload code");
    check_bit(travel_enable, 1'b0, "travel inhibited");
    check_bit(door_close_cmd, 1'b0, "close refused in overload");
    close_btn = 1'b0;
    overload = 1'b0;
    wait_for(4, 1'b0, "lamp off");
    check_bit(buzzer, 1'b0, "buzzer off");
    check_vec(overload_indication_code, 8'h00, "code cleared");
    close_btn = 1'b1;
    wait_for(2, 1'b1, "service resumes");
    close_btn = 1'b0;
    // ahead call latched, behind call dropped
    car_call_btn = 8'h21;
    step(1);
    car_call_btn = 8'h00;
    step(3);
    check_vec(car_calls, 8'h20, "car calls");
    // landing call stops only in matching direction, or by reversal at the top floor
    car_stopped = 1'b0;
    land_up_btn = 8'h10;
    land_down_btn = 8'h88;
    step(1);
    land_up_btn = 8'h00;
    land_down_btn = 8'h00;
    cur_floor = 3'h3;
    step(3);
    check_bit(stop_here, 1'b0, "no stop opposite call");
    cur_floor = 3'h4;
    wait_for(3, 1'b1, "stop same direction");
    cur_floor = 3'h6;
    step(3);
    check_bit(stop_here, 1'b0, "no stop without call");
    cur_floor = 3'h7;
    step(3);
    check_bit(stop_here, 1'b1, "stop at top floor");
    car_stopped = 1'b1;
    sel_attendant = 1'b1;
    step(3);
    check_vec({5'h00, mode}, 8'h02, "attendant mode");
    for (int i = 0; i < 3; i++) begin
      {insp_top, insp_car, insp_cabinet} = 3'b100 >> i;
      step(3);
      check_vec({5'h00, mode}, 8'h04, "inspection mode");
    end
    check_vec(car_calls | land_up_calls | land_down_calls, 8'h00, "calls cleared");
    insp_up_btn = 1'b1;
    step(3);
    check_bit(insp_run_up, 1'b1, "run up held");
    insp_up_btn = 1'b0;
    step(3);
    check_bit(insp_run_up, 1'b0, "stop on release");
    insp_down_btn = 1'b1;
    step(3);
    check_bit(insp_run_down, 1'b1, "run down held");
    insp_down_btn = 1'b0;
    step(3);
    check_bit(insp_run_down, 1'b0, "stop down on release");
    // reset mid-run with the car level, attendant then auto
    {insp_top, insp_car, insp_cabinet} = 3'b000;
    sel_attendant = 1'b1;
    hold_time = 8'h00;
    resetn = 1'b0;
    step(4);
    check_vec({5'h00, mode}, 8'h04, "mode in reset");
    check_bit(door_open_cmd, 1'b0, "door idle in reset");
    resetn = 1'b1;
    step(2);
    check_bit(door_open_cmd, 1'b1, "open at power-up");
    while (door_open_lim !== 1'b1 && cycles < 19000) step(1);
    step(10);
    check_bit(door_close_cmd, 1'b0, "attendant holds door");
    sel_attendant = 1'b0;
    wait_for(1, 1'b1, "auto close after hold");
    conclude();
  end
endmodule
`default_nettype wire
